// [hw/mxp_ports.sv]
// Port E, F, G and H pin logic with its AXI4-Lite register file.
//
// The AXI4-Lite interface to the registers is this design's own decision.
`default_nettype none
`include "mxp_defs.svh"

// How it works
// - Port H direction bit: 0 input, 1 output.
// - Port G direction bit: 0 input, 1 output.
// - Single-chip/boot: port F resets as input, pull-ups off.
// - Expanded/test: F drives address, value register unmapped.
// - Reset makes all port H pins inputs.
// - Expanded/test reset enables PH7 program select.
// - Expanded/test: enabled chip select forces its H pin out.
// - Enabled pulse-width channel forces its H pin out.
// - Overrides keep direction bits; control returns afterwards.
// - Reset makes all port G pins inputs.
// - Expanded/test: PG7 carries read/write strobe.
// - Strobe forces PG7 out, direction bit untouched.
// - G assignment bit selects I/O or expansion address.
// - Assignment forces output, direction bit kept.
// - G assignment bits 7:6 read zero.
// - Pull-up enable bit switches port pull-ups.
// - Pull-up bits count only with gate set.
// - Pull-up assignment bits 7:4 read zero.
// - F and B pull-ups idle in expanded mode.
module mxp_ports
    import mxp_pkg::*;
(
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic [`MXP_ADDR_W-1:0] awaddr,
    input  wire logic                  awvalid,
    output var  logic                  awready,
    input  wire logic [31:0]           wdata,
    input  wire logic [3:0]            wstrb,
    input  wire logic                  wvalid,
    output var  logic                  wready,
    output var  logic [1:0]            bresp,
    output var  logic                  bvalid,
    input  wire logic                  bready,
    input  wire logic [`MXP_ADDR_W-1:0] araddr,
    input  wire logic                  arvalid,
    output var  logic                  arready,
    output var  logic [31:0]           rdata,
    output var  logic [1:0]            rresp,
    output var  logic                  rvalid,
    input  wire logic                  rready,
    input  wire logic [1:0]            mode_strap,
    input  wire logic [7:0]            pe_in,
    input  wire logic [7:0]            pf_in,
    input  wire logic [7:0]            pg_in,
    input  wire logic [7:0]            ph_in,
    output var  mxp_pins_t             pf_out,
    output var  mxp_pins_t             pg_out,
    output var  mxp_pins_t             ph_out,
    output var  mxp_pullup_t           pullup_on,
    input  wire logic [7:0]            addr_lo,
    input  wire logic [5:0]            expansion_address_line,
    input  wire logic                  bus_rw,
    input  wire logic [3:0]            cs_enable,
    input  wire logic [3:0]            cs_level,
    input  wire logic [3:0]            pwm_enable,
    input  wire logic [3:0]            pulse_width_output
);

    // Pin and strap synchronisers; stage one feeds stage two only.
    // Two stages keep a pin edge from reaching decode logic metastable.
    logic [33:0] sync1_q;              // First stage of all pin inputs.
    logic [33:0] sync2_q;              // Second stage, safe to read.
    wire  [7:0]  pe_s = sync2_q[7:0];  // Port E pins, analog-shared.
    wire  [7:0]  pf_s = sync2_q[15:8]; // Port F pins.
    wire  [7:0]  pg_s = sync2_q[23:16];// Port G pins.
    wire  [7:0]  ph_s = sync2_q[31:24];// Port H pins.

    // Software-visible state.
    mxp_mode_t   mode_q;               // Mode caught while in reset.
    logic [7:0]  f_dir_q;              // Port F direction bits.
    logic [7:0]  g_dir_q;              // Port G direction bits.
    logic [7:0]  h_dir_q;              // Port H direction bits.
    logic [7:0]  f_lat_q;              // Port F output latch.
    logic [7:0]  g_lat_q;              // Port G output latch.
    logic [7:0]  h_lat_q;              // Port H output latch.
    logic [7:0]  gasn_q;               // Port G assignment, 5:0 used.
    logic [7:0]  pua_q;                // Pull-up assignment, 3:0 used.
    logic [7:0]  ctrl_q;               // Gate and program-select bits.

    // Write address and write data channel holding state.
    logic [`MXP_ADDR_W-1:0] aw_addr_q; // Captured write address.
    logic        aw_full_q;            // Write address held.
    logic [31:0] w_data_q;             // Captured write data.
    logic        w_lane0_q;            // Low byte lane was enabled.
    logic        w_full_q;             // Write data held.

    // Synchronise pins; the strap is caught during reset.
    always_ff @(posedge aclk) begin
        sync1_q <= {mode_strap, ph_in, pg_in, pf_in, pe_in};
        sync2_q <= sync1_q;
    end

    // Mode decode: expanded and test both run the external bus.
    wire exp_mode = (mode_q == MXP_EXPANDED) || (mode_q == MXP_TEST);
    wire pu_gate  = ctrl_q[`MXP_CTRL_GATE];

    // Forced outputs per pin; direction bits are never touched by these.
    // Trade-off: forcing is an OR over the direction bits, so software
    // never sees its stored direction disturbed by a takeover.
    wire prog_sel = cs_enable[3] | ctrl_q[`MXP_CTRL_PROG];
    wire [3:0] cs_on = {prog_sel, cs_enable[2:0]} & {4{exp_mode}};
    wire [7:0] h_force = {cs_on, pwm_enable};
    wire [7:0] g_force = {exp_mode, 1'b0, gasn_q[5:0]};
    wire [7:0] f_oe  = exp_mode ? 8'hff : f_dir_q;
    wire [7:0] g_oe  = g_dir_q | g_force;
    wire [7:0] h_oe  = h_dir_q | h_force;

    // Pin values: alternate function wins where it is enabled.
    wire [7:0] f_val = exp_mode ? addr_lo : f_lat_q;
    wire [7:0] g_alt = {bus_rw, 1'b0, expansion_address_line};
    wire [7:0] g_val = (g_alt & g_force) | (g_lat_q & ~g_force);
    wire [7:0] h_alt = {cs_level, pulse_width_output};
    wire [7:0] h_val = (h_alt & h_force) | (h_lat_q & ~h_force);

    // Port readback: latch for outputs, pin level for inputs.
    // A limitation: reading a forced pin gives the latch, not the pin.
    wire [7:0] f_rd = (f_lat_q & f_oe) | (pf_s & ~f_oe);
    wire [7:0] g_rd = (g_lat_q & g_oe) | (pg_s & ~g_oe);
    wire [7:0] h_rd = (h_lat_q & h_oe) | (ph_s & ~h_oe);

    // Write decode; the port F value register is absent in bus modes.
    wire [`MXP_IDX_W-1:0] w_idx = aw_addr_q[`MXP_ADDR_W-1:2];
    wire do_write = aw_full_q & w_full_q & ~bvalid;
    wire wr_en    = do_write & w_lane0_q;
    wire [7:0] wb = w_data_q[7:0];
    wire f_val_map_w = (w_idx == `MXP_IDX_FVAL) & ~exp_mode;
    wire w_hit = (w_idx == `MXP_IDX_FDIR) | f_val_map_w
               | (w_idx == `MXP_IDX_EVAL) | (w_idx == `MXP_IDX_PUA)
               | (w_idx == `MXP_IDX_GASN) | (w_idx == `MXP_IDX_CTRL)
               | (w_idx == `MXP_IDX_HVAL) | (w_idx == `MXP_IDX_HDIR)
               | (w_idx == `MXP_IDX_GVAL) | (w_idx == `MXP_IDX_GDIR);

    // Read decode and data selection.
    wire [`MXP_IDX_W-1:0] r_idx = araddr[`MXP_ADDR_W-1:2];
    wire f_val_map_r = (r_idx == `MXP_IDX_FVAL) & ~exp_mode;
    logic [7:0] r_sel;                 // Selected register byte.
    logic       r_hit;                 // Address maps to a register.
    always_comb begin
        r_hit = 1'b1;
        case (r_idx)
            `MXP_IDX_FDIR: r_sel = f_dir_q;
            `MXP_IDX_EVAL: r_sel = pe_s;
            `MXP_IDX_PUA:  r_sel = pua_q & `MXP_PUA_MASK;
            `MXP_IDX_GASN: r_sel = gasn_q & `MXP_GASN_MASK;
            `MXP_IDX_CTRL: r_sel = ctrl_q & `MXP_CTRL_MASK;
            `MXP_IDX_HVAL: r_sel = h_rd;
            `MXP_IDX_HDIR: r_sel = h_dir_q;
            `MXP_IDX_GVAL: r_sel = g_rd;
            `MXP_IDX_GDIR: r_sel = g_dir_q;
            default: begin
                // Port F value reads only when it is in the map.
                r_sel = f_val_map_r ? f_rd : 8'h00;
                r_hit = f_val_map_r;
            end
        endcase
    end

    // Mode capture and register writes. The reset is synchronous, so
    // sampling the synchronised strap in the reset branch is safe.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_q  <= mxp_mode_t'(sync2_q[33:32]);
            f_dir_q <= `MXP_DIR_RST;
            g_dir_q <= `MXP_DIR_RST;
            h_dir_q <= `MXP_DIR_RST;
            gasn_q  <= `MXP_GASN_RST;
            pua_q   <= `MXP_PUA_RST;
            ctrl_q  <= `MXP_CTRL_RST;
        end else if (wr_en) begin
            case (w_idx)
                `MXP_IDX_FDIR: f_dir_q <= wb;
                `MXP_IDX_PUA:  pua_q   <= wb & `MXP_PUA_MASK;
                `MXP_IDX_GASN: gasn_q  <= wb & `MXP_GASN_MASK;
                `MXP_IDX_CTRL: ctrl_q  <= wb & `MXP_CTRL_MASK;
                `MXP_IDX_HDIR: h_dir_q <= wb;
                `MXP_IDX_GDIR: g_dir_q <= wb;
                default: begin
                    // Latches are handled below; read-only registers ignore writes.
                end
            endcase
        end
    end

    // Output latches have no reset: a pin drives its latch only once software
    // sets its direction, but a forced pin shows its latch on readback.
    always_ff @(posedge aclk) begin
        if (wr_en && f_val_map_w) f_lat_q <= wb;
        if (wr_en && w_idx == `MXP_IDX_GVAL) g_lat_q <= wb;
        if (wr_en && w_idx == `MXP_IDX_HVAL) h_lat_q <= wb;
    end

    // Pin drivers, registered so outputs come from flip-flops.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pf_out <= '{o: 8'h00, oe_n: 8'hff};
            pg_out <= '{o: 8'h00, oe_n: 8'hff};
            ph_out <= '{o: 8'h00, oe_n: 8'hff};
            pullup_on <= '0;
        end else begin
            pf_out <= '{o: f_val, oe_n: ~f_oe};
            pg_out <= '{o: g_val, oe_n: ~g_oe};
            ph_out <= '{o: h_val, oe_n: ~h_oe};
            // Pull-ups need the gate; F and B lose them to the bus.
            pullup_on.h <= pu_gate & pua_q[`MXP_PUA_H];
            pullup_on.g <= pu_gate & pua_q[`MXP_PUA_G];
            pullup_on.f <= pu_gate & pua_q[`MXP_PUA_F] & ~exp_mode;
            pullup_on.b <= pu_gate & pua_q[`MXP_PUA_B] & ~exp_mode;
        end
    end

    // Write channels: address and data are taken in either order and
    // held until both are in; the response follows one cycle later.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready   <= 1'b1;
            wready    <= 1'b1;
            aw_full_q <= 1'b0;
            w_full_q  <= 1'b0;
            bvalid    <= 1'b0;
            bresp     <= `MXP_RESP_OKAY;
        end else begin
            if (awvalid && awready) begin
                aw_addr_q <= awaddr;
                aw_full_q <= 1'b1;
                awready   <= 1'b0;
            end
            if (wvalid && wready) begin
                w_data_q  <= wdata;
                w_lane0_q <= wstrb[0];
                w_full_q  <= 1'b1;
                wready    <= 1'b0;
            end
            if (do_write) begin
                aw_full_q <= 1'b0;
                w_full_q  <= 1'b0;
                bvalid    <= 1'b1;
                bresp     <= w_hit ? `MXP_RESP_OKAY : `MXP_RESP_DECERR;
            end
            if (bvalid && bready) begin
                // Reopen both channels only once the answer is gone.
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    // Read channel: data is sampled at the address handshake.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= 32'h0000_0000;
            rresp   <= `MXP_RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid  <= 1'b1;
            rdata   <= {24'h00_0000, r_sel};
            rresp   <= r_hit ? `MXP_RESP_OKAY : `MXP_RESP_DECERR;
        end else if (rvalid && rready) begin
            rvalid  <= 1'b0;
            arready <= 1'b1;
        end
    end

    // Checks on the pin logic and the bus answers.
    // Reset may be released by an update right at a clock edge, so the
    // disable condition can already read high at an edge where the logic
    // still took its reset branch. The F address and strobe checks also demand a
    // sampled high reset, and the reset checks key on the rising level
    // of reset rather than on a low cycle that the disable would hide.
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // First edge after release: direction bits clear, pins released.
    property p_h_dir_reset;
        $rose(aresetn) |-> h_dir_q == 8'h00 && ph_out.oe_n == 8'hff;
    endproperty
    a_h_dir_reset: assert property (p_h_dir_reset)
        else $error("Port H not all inputs after reset.");

    // The same holds for port G at the first edge after release.
    property p_g_dir_reset;
        $rose(aresetn) |-> g_dir_q == 8'h00 && pg_out.oe_n == 8'hff;
    endproperty
    a_g_dir_reset: assert property (p_g_dir_reset)
        else $error("Port G not all inputs after reset.");

    // In bus modes port F follows the low address one cycle later.
    property p_f_addr;
        aresetn && exp_mode |=> pf_out.o == $past(addr_lo)
            && pf_out.oe_n == 8'h00;
    endproperty
    a_f_addr: assert property (p_f_addr)
        else $error("Port F does not carry the low address.");

    // The port F value index must answer with a decode error here.
    property p_f_unmapped;
        arvalid && arready && exp_mode && r_idx == `MXP_IDX_FVAL
            |=> rvalid && rresp == `MXP_RESP_DECERR;
    endproperty
    a_f_unmapped: assert property (p_f_unmapped)
        else $error("Port F value register answered in bus mode.");

    // One channel stands for all four; they share the same logic.
    property p_pwm_force;
        pwm_enable[0] |=> ph_out.oe_n[0] == 1'b0
            && ph_out.o[0] == $past(pulse_width_output[0]);
    endproperty
    a_pwm_force: assert property (p_pwm_force)
        else $error("Pulse-width pin not forced to output.");

    // Once the channel is off the stored direction bit rules again.
    property p_h_dir_back;
        !pwm_enable[1] |=> ph_out.oe_n[1] == !$past(h_dir_q[1]);
    endproperty
    a_h_dir_back: assert property (p_h_dir_back)
        else $error("Direction bit lost control of a port H pin.");

    // The strobe pin is driven whatever the direction bit says.
    property p_rw_strobe;
        aresetn && exp_mode |=> pg_out.oe_n[7] == 1'b0
            && pg_out.o[7] == $past(bus_rw);
    endproperty
    a_rw_strobe: assert property (p_rw_strobe)
        else $error("Read/write strobe not on port G bit 7.");

    // An assigned pin carries its expansion address line.
    property p_xa_force;
        gasn_q[2] |=> pg_out.oe_n[2] == 1'b0
            && pg_out.o[2] == $past(expansion_address_line[2]);
    endproperty
    a_xa_force: assert property (p_xa_force)
        else $error("Expansion address not driven on port G.");

    // Without the gate no pull-up may be switched on.
    property p_gate;
        !pu_gate |=> pullup_on == 4'h0;
    endproperty
    a_gate: assert property (p_gate)
        else $error("Pull-up active with the gate clear.");

    // The unused assignment bits must never come back as one.
    property p_unimpl;
        rvalid && $past(r_idx) == `MXP_IDX_GASN && $rose(rvalid)
            |-> rdata[7:6] == 2'b00;
    endproperty
    a_unimpl: assert property (p_unimpl)
        else $error("Unimplemented assignment bits read as one.");

    // Both halves taken at one edge: the answer stands two edges on.
    property p_write_answer;
        awvalid && awready && wvalid && wready |-> ##2 bvalid;
    endproperty
    a_write_answer: assert property (p_write_answer)
        else $error("Write response missing two cycles after handshake.");

    // Covers show that good writes, reads and takeovers do occur.
    c_write: cover property (bvalid && bready && bresp == `MXP_RESP_OKAY);
    c_read:  cover property (rvalid && rready && rresp == `MXP_RESP_OKAY);
    c_pwm:   cover property (pwm_enable[3] && !h_dir_q[3]);
    c_bus:   cover property (exp_mode && gasn_q != 8'h00);
    // A decode error must also be reached, for unmapped indices.
    c_decerr: cover property (bvalid && bready && bresp == `MXP_RESP_DECERR);

endmodule : mxp_ports
`default_nettype wire

// [hw/mxp_defs.svh]
// Register indices, field masks, reset values and bus codes for the ports.
`ifndef MXP_DEFS_SVH
`define MXP_DEFS_SVH
`define MXP_ADDR_W       10
`define MXP_IDX_W        8
`define MXP_IDX_FDIR     8'h03
`define MXP_IDX_FVAL     8'h05
`define MXP_IDX_EVAL     8'h0a
`define MXP_IDX_PUA      8'h2c
`define MXP_IDX_GASN     8'h2d
`define MXP_IDX_CTRL     8'h3f
`define MXP_IDX_HVAL     8'h7c
`define MXP_IDX_HDIR     8'h7d
`define MXP_IDX_GVAL     8'h7e
`define MXP_IDX_GDIR     8'h7f
`define MXP_GASN_MASK    8'h3f
`define MXP_PUA_MASK     8'h0f
`define MXP_CTRL_MASK    8'h03
`define MXP_DIR_RST      8'h00
`define MXP_GASN_RST     8'h00
`define MXP_PUA_RST      8'h00
`define MXP_CTRL_RST     8'h02
`define MXP_CTRL_GATE    0
`define MXP_CTRL_PROG    1
`define MXP_PUA_H        0
`define MXP_PUA_G        1
`define MXP_PUA_F        2
`define MXP_PUA_B        3
`define MXP_RESP_OKAY    2'b00
`define MXP_RESP_DECERR  2'b11
`endif

// [hw/mxp_pkg.sv]
// Types shared by the multiplexed port block.
`default_nettype none
package mxp_pkg;
    // Operating mode as strapped on the mode pins.
    typedef enum logic [1:0] {
        MXP_SINGLE   = 2'b00,
        MXP_EXPANDED = 2'b01,
        MXP_BOOT     = 2'b10,
        MXP_TEST     = 2'b11
    } mxp_mode_t;
    // One 8-bit pin group as driven by the block; oe_n low drives.
    typedef struct packed {
        logic [7:0] o;
        logic [7:0] oe_n;
    } mxp_pins_t;
    // Pull-up requests per port, already gated.
    typedef struct packed {
        logic b;
        logic f;
        logic g;
        logic h;
    } mxp_pullup_t;
endpackage : mxp_pkg
`default_nettype wire

// [tb/mxp_board.sv]
// Board-side model that resolves every port F, G and H pin from all of its drivers.
`default_nettype none

module mxp_board
    import mxp_pkg::*;
(
    input  wire logic        aclk,
    input  wire mxp_pins_t   pf_out,
    input  wire mxp_pins_t   pg_out,
    input  wire mxp_pins_t   ph_out,
    input  wire mxp_pullup_t pullup_on,
    input  wire logic [23:0] drv,
    input  wire logic [23:0] en,
    output var  logic [7:0]  pf_in,
    output var  logic [7:0]  pg_in,
    output var  logic [7:0]  ph_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // A released pin with no pull-up wanders; it flips every cycle.
    logic [7:0] flt_q = 8'h5a;

    // Stops a floating line from showing its last driven level.
    always_ff @(posedge aclk) begin
        flt_q <= ~flt_q;
    end

    // Chip drive wins, then the board's drivers, then pull-ups.
    function automatic logic [7:0] lvl(mxp_pins_t p, logic [7:0] d,
                                       logic [7:0] e, logic pu,
                                       logic [7:0] f);
        logic [7:0] idle;
        idle = pu ? 8'hff : f;
        return (~p.oe_n & p.o) | (p.oe_n & ((e & d) | (~e & idle)));
    endfunction

    assign pf_in = lvl(pf_out, drv[23:16], en[23:16], pullup_on.f, flt_q);
    assign pg_in = lvl(pg_out, drv[15:8], en[15:8], pullup_on.g, flt_q);
    assign ph_in = lvl(ph_out, drv[7:0], en[7:0], pullup_on.h, flt_q);
endmodule // mxp_board
`default_nettype wire

// [tb/test_multiplexed_io_ports_efgh.sv]
// Self-checking testbench for the multiplexed port block.
`default_nettype none
`include "mxp_defs.svh"

module test_multiplexed_io_ports_efgh import mxp_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [1:0] OK = `MXP_RESP_OKAY;
    localparam logic [1:0] DE = `MXP_RESP_DECERR;

    logic        aclk = 1'b0, aresetn = 1'b0;
    logic [9:0]  awaddr = 10'h000, araddr = 10'h000;
    logic [31:0] wdata = 32'h0, rdata;
    logic [3:0]  wstrb = 4'hf;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, bus_rw = 1'b0;
    logic [1:0]  mode_strap = 2'b00, bresp, rresp;
    logic [7:0]  pe_in = 8'h00, addr_lo = 8'h00;
    logic [5:0]  ext_addr = 6'h00;
    logic [3:0]  cs_en = 4'h0, cs_lv = 4'h0, pwm_en = 4'h0, pwm_out = 4'h0;
    logic        awready, wready, bvalid, arready, rvalid, ex;
    logic [7:0]  pf_in, pg_in, ph_in, dh, dg, df, lh, lg, lf, mh, mg, tg;
    mxp_pins_t   pf_out, pg_out, ph_out, ge;
    mxp_pullup_t pullup_on;
    logic [23:0] bd_drv = 24'h0, bd_en = 24'hffffff;
    logic [10:0] exp_q[$];
    logic [10:0] ent;
    int          err_total = 0, checks = 0;

    always #2.5 aclk = ~aclk;

    mxp_ports u_mxp_ports (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready),
        .mode_strap(mode_strap), .pe_in(pe_in), .pf_in(pf_in),
        .pg_in(pg_in), .ph_in(ph_in), .pf_out(pf_out), .pg_out(pg_out),
        .ph_out(ph_out), .pullup_on(pullup_on), .addr_lo(addr_lo),
        .expansion_address_line(ext_addr), .bus_rw(bus_rw),
        .cs_enable(cs_en), .cs_level(cs_lv), .pwm_enable(pwm_en),
        .pulse_width_output(pwm_out)
    );

    mxp_board u_mxp_board (
        .aclk(aclk), .pf_out(pf_out), .pg_out(pg_out), .ph_out(ph_out),
        .pullup_on(pullup_on), .drv(bd_drv), .en(bd_en), .pf_in(pf_in),
        .pg_in(pg_in), .ph_in(ph_in)
    );

    // Expected pins: forced bits drive their function, others obey dir.
    function automatic mxp_pins_t px(logic [7:0] d, logic [7:0] l,
                                     logic [7:0] fm, logic [7:0] fv);
        return '{o: (fm & fv) | (~fm & l), oe_n: ~(d | fm)};
    endfunction

    // Bus write; the response note goes on the queue first.
    task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                      input logic [1:0] er);
        exp_q.push_back({1'b0, er, 8'h00});
        awaddr  <= {idx, 2'b00};
        wdata   <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!(bvalid && bready));
    endtask

    // Bus read; data is only compared on an OKAY answer.
    task automatic rd(input logic [7:0] idx, input logic [7:0] d,
                      input logic [1:0] er);
        exp_q.push_back({1'b1, er, d});
        araddr  <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!(rvalid && rready));
    endtask

    task automatic chk_bus(input logic r, input logic [1:0] rsp,
                           input logic [31:0] d, input logic [10:0] e);
        checks++;
        if (r !== e[10] || rsp !== e[9:8] ||
            (r && rsp === OK && d !== {24'h0, e[7:0]})) begin
            err_total++;
            $display("BAD %0t bus answer differs", $time);
        end
    endtask

    // Only driven bits of o matter; undriven latches may be unknown.
    task automatic chk_pin(input mxp_pins_t g, input mxp_pins_t e);
        checks++;
        if (g.oe_n !== e.oe_n || (g.o & ~e.oe_n) !== (e.o & ~e.oe_n)) begin
            err_total++;
            $display("BAD %0t pin state differs", $time);
        end
    endtask

    task automatic chk_pu(input mxp_pullup_t g, input logic [3:0] e);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("BAD %0t pull-up state differs", $time);
        end
    endtask

    // Result watcher: every bus answer takes the oldest note.
    always @(posedge aclk) begin
        if ((bvalid && bready) || (rvalid && rready)) begin
            ent = exp_q.pop_front();
            chk_bus(rvalid && rready, rvalid ? rresp : bresp, rdata, ent);
        end
    end

    task automatic do_reset(input logic [1:0] m);
        aresetn    <= 1'b0;
        mode_strap <= m;
        {addr_lo, ext_addr, cs_lv, pwm_out, bus_rw} <= 23'($urandom);
        {pe_in, bd_drv} <= 32'($urandom);
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
    endtask

    task automatic run_mode();
        ex = mode_strap[0];
        tg = {ex, 7'h00};
        repeat (3) @(posedge aclk);
        chk_pin(pf_out, px(8'h00, 8'h00, {8{ex}}, addr_lo));
        chk_pin(pg_out, px(8'h00, 8'h00, tg, {bus_rw, 7'h00}));
        chk_pin(ph_out, px(8'h00, 8'h00, tg, {cs_lv, 4'h0}));
        chk_pu(pullup_on, 4'h0);
        rd(`MXP_IDX_FDIR, 8'h00, OK);
        rd(`MXP_IDX_HDIR, 8'h00, OK);
        rd(`MXP_IDX_GDIR, 8'h00, OK);
        rd(`MXP_IDX_FVAL, bd_drv[23:16], ex ? DE : OK);
        rd(8'h40, 8'h00, DE);
        wr(8'h40, 8'hff, DE);
        // Assignment bits force G out while its direction stays zero.
        wr(`MXP_IDX_GASN, 8'hff, OK);
        rd(`MXP_IDX_GASN, 8'h3f, OK);
        repeat (2) @(posedge aclk);
        ge = px(8'h00, 8'h00, tg | 8'h3f, {bus_rw, 1'b0, ext_addr});
        chk_pin(pg_out, ge);
        rd(`MXP_IDX_GDIR, 8'h00, OK);
        wr(`MXP_IDX_GASN, 8'h00, OK);
        // Pull-ups count only once the gate bit is set.
        wr(`MXP_IDX_PUA, 8'hff, OK);
        rd(`MXP_IDX_PUA, 8'h0f, OK);
        repeat (2) @(posedge aclk);
        chk_pu(pullup_on, 4'h0);
        wr(`MXP_IDX_CTRL, 8'h03, OK);
        wr(`MXP_IDX_HVAL, 8'h00, OK);
        bd_en <= 24'hffff00;
        repeat (4) @(posedge aclk);
        chk_pu(pullup_on, ex ? 4'h3 : 4'hf);
        rd(`MXP_IDX_HVAL, {~ex, 7'h7f}, OK);
        bd_en <= 24'hffffff;
        // Random directions and latches on all three ports.
        {dh, dg, df, lh, lg, lf} = 48'({$urandom, $urandom});
        wr(`MXP_IDX_HDIR, dh, OK);
        wr(`MXP_IDX_GDIR, dg, OK);
        wr(`MXP_IDX_FDIR, df, OK);
        wr(`MXP_IDX_HVAL, lh, OK);
        wr(`MXP_IDX_GVAL, lg, OK);
        wr(`MXP_IDX_FVAL, lf, ex ? DE : OK);
        repeat (2) @(posedge aclk);
        ge = ex ? px(8'h00, 8'h00, 8'hff, addr_lo) : px(df, lf, 8'h0, 8'h0);
        chk_pin(pf_out, ge);
        chk_pin(pg_out, px(dg, lg, tg, {bus_rw, 7'h00}));
        chk_pin(ph_out, px(dh, lh, tg, {cs_lv, 4'h0}));
        mh = dh | tg;
        mg = dg | tg;
        lf = (df & lf) | (~df & bd_drv[23:16]);
        rd(`MXP_IDX_HVAL, (mh & lh) | (~mh & bd_drv[7:0]), OK);
        rd(`MXP_IDX_GVAL, (mg & lg) | (~mg & bd_drv[15:8]), OK);
        rd(`MXP_IDX_EVAL, pe_in, OK);
        if (!ex) rd(`MXP_IDX_FVAL, lf, OK);
        // A write without the low byte lane must leave the register alone.
        wstrb <= 4'he;
        wr(`MXP_IDX_HDIR, ~dh, OK);
        wstrb <= 4'hf;
        rd(`MXP_IDX_HDIR, dh, OK);
        // Chip selects and pulse-width channels take over port H.
        cs_en  <= 4'($urandom);
        pwm_en <= 4'($urandom);
        repeat (3) @(posedge aclk);
        ge = px(dh, lh, {ex ? (cs_en | 4'h8) : 4'h0, pwm_en}, {cs_lv, pwm_out});
        chk_pin(ph_out, ge);
        rd(`MXP_IDX_HDIR, dh, OK);
        cs_en  <= 4'h0;
        pwm_en <= 4'h0;
        repeat (3) @(posedge aclk);
        chk_pin(ph_out, px(dh, lh, tg, {cs_lv, 4'h0}));
    endtask

    task automatic final_report();
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Four modes take well under a thousand cycles each.
    initial begin
        repeat (20000) @(posedge aclk);
        err_total++;
        final_report();
    end

    initial begin
        void'($urandom(25));
        for (int m = 0; m < 4; m++) begin
            do_reset(2'(m));
            run_mode();
        end
        final_report();
    end
endmodule // test_multiplexed_io_ports_efgh
`default_nettype wire
